//--- src/link_defs.vh
// Purpose: constants for the coil-line challenge link
// Assumes: 200 MHz clock, times counted in half time elements
// Notes: counts derive from printed times and the clock rate
//
// How it works
// - field entry starts challenge mode and an acknowledge pulse train
// - no reply in 50 ms with rf echo set: 2 s rf send, code 000
// - a 2 time element start signal from the decoder stops the train
// - after start an opcode is taken, then 0, 16 or 32 data bits
// - time element is 200 us, or 100 us with the rate bit set
// - each command bit is the gap between two rising coil edges
// - command bit: 4 te (min 3.5) is one, 6 te (min 5.5) zero
// - response bits last 2 te for a one and 3 te for a zero
// - at least 6.5 ms passes between a read command and its answer
// - one 16-bit nonvolatile word write ends within 30 ms
// - each response is preamble 0 then 1, then 16 or 32 bits
// - a response goes out once, then a new command is taken
// - opcode picks challenge algorithm and key; dual key allows two
// - a stored word is followed by two 1 te pulses 1 te apart
// - serial and configuration writes need the transport code first
// - a new configuration word acts only after a reset
// - a read yields exactly one 16-bit answer
// - program opcode erases, takes 18 acked words, then sends them back
// - after erase the configuration reloads, so tuning reads 0000
// - five-bit opcodes select read, program, write or challenge
`ifndef LINK_DEFS_VH
`define LINK_DEFS_VH
`define CLK_MHZ        200
`define TE_SLOW_US     200
`define TE_FAST_US     100
`define HALF_SLOW_CYC  (`TE_SLOW_US*`CLK_MHZ/2)
`define HALF_FAST_CYC  (`TE_FAST_US*`CLK_MHZ/2)
`define ACK_WAIT_MS    50
`define ACK_WAIT_CYC   (`ACK_WAIT_MS*`CLK_MHZ*1000)
`define RF_TIME_MS     2000
`define RF_CYC         (`RF_TIME_MS*`CLK_MHZ*1000)
`define RESP_WAIT_US   6500
`define RESP_WAIT_CYC  (`RESP_WAIT_US*`CLK_MHZ)
`define WRITE_MS       30
`define WRITE_CYC      (`WRITE_MS*`CLK_MHZ*1000)
`define ONE_MIN_H      6'h07
`define ZERO_MIN_H     6'h0B
`define START_MIN_H    4'h3
`define ACK_LAST_H     4'h7
`define RSP_ONE_H      3'h3
`define RSP_ZERO_H     3'h5
`define CFG_RATE_BIT   0
`define CFG_ECHO_BIT   1
`define CFG_DUAL_BIT   2
`define CFG_DEFAULT    16'h0000
`define MAP_WORDS      18
`define MAP_LAST       5'h11
`define KEY1_BASE      5'h07
`define KEY2_BASE      5'h0B
`define USR_BASE       5'h03
`define OP_SELECT      5'h00
`define OP_PROGRAM     5'h08
`define SWITCH_ECHO    3'h0
`endif

//--- src/te_divider.v
// Purpose: half time element tick generator
// Assumes: half periods are given in clock cycles
// Notes: rate change restarts the count
`timescale 1ns/1ps
`default_nettype none
module te_divider #(
    parameter [15:0] HALF_SLOW = 16'h4E20,
    parameter [15:0] HALF_FAST = 16'h2710
) (
    input  wire clock,
    input  wire rstn,
    input  wire fast,
    output reg  tick
);
    reg  [15:0] cnt;
    reg         fast_q;
    wire [15:0] last = fast ? HALF_FAST - 16'h0001
                            : HALF_SLOW - 16'h0001;

    always @(posedge clock) begin
        if (!rstn) begin
            cnt    <= 16'h0000;
            tick   <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            fast_q <= fast;
            tick   <= 1'b0;
            if (cnt >= last || fast != fast_q) begin
                cnt  <= 16'h0000;
                tick <= (fast == fast_q);
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
endmodule // te_divider
`default_nettype wire

//--- src/word_fifo.v
// Purpose: small response word buffer
// Assumes: depth is a power of two, AW its log2
// Notes: in_ready low when full stalls the producer
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter W  = 17,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire         clock,
    input  wire         rstn,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    localparam [AW:0] FULL = D[AW:0];
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wp;
    reg [AW-1:0] rp;
    reg [AW:0]   count;
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != FULL);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rp];

    always @(posedge clock) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            wp    <= {AW{1'b0}};
            rp    <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp <= wp + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp <= rp + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // word_fifo
`default_nettype wire

//--- src/transponder_challenge_link.v
// Purpose: device end of the coil-line challenge and memory link
// Assumes: coil and field inputs synchronous to CLOCK
// Notes: coil line b mirrors coil line a
`include "link_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module transponder_challenge_link #(
    parameter [15:0] HALF_SLOW  = `HALF_SLOW_CYC,
    parameter [15:0] HALF_FAST  = `HALF_FAST_CYC,
    parameter [31:0] ACK_WAIT   = `ACK_WAIT_CYC,
    parameter [31:0] RF_TIME    = `RF_CYC,
    parameter [31:0] RESP_WAIT  = `RESP_WAIT_CYC,
    parameter [31:0] WRITE_TIME = `WRITE_CYC,
    parameter [31:0] TRANSPORT  = 32'h5A3C_96E1
) (
    input  wire       CLOCK,
    input  wire       RSTN,
    input  wire       FIELD_PRESENT,
    input  wire       COIL_LINE_A_IN,
    output reg        COIL_LINE_A_OUT,
    output reg        COIL_LINE_A_OE,
    output reg        COIL_LINE_B_OUT,
    output reg        COIL_LINE_B_OE,
    output reg        RF_ACTIVE,
    output reg  [2:0] SWITCH_FUNCTION_CODE,
    output reg        LINK_ACTIVE
);
    localparam [3:0] ST_OFF   = 4'h0;
    localparam [3:0] ST_ACK   = 4'h1;
    localparam [3:0] ST_RF    = 4'h2;
    localparam [3:0] ST_OPC   = 4'h3;
    localparam [3:0] ST_DATA  = 4'h4;
    localparam [3:0] ST_WRITE = 4'h5;
    localparam [3:0] ST_WACK  = 4'h6;
    localparam [3:0] ST_PUSH  = 4'h7;
    localparam [1:0] TX_IDLE  = 2'h0;
    localparam [1:0] TX_WAIT  = 2'h1;
    localparam [1:0] TX_BIT   = 2'h2;

    reg  [15:0] mem [0:`MAP_WORDS-1];
    reg  [3:0]  state;
    reg  [15:0] cfg_active;
    reg         cfg_loaded;
    reg         coil_prev;
    reg  [5:0]  iv;
    reg  [3:0]  hcnt;
    reg         ref_needed;
    reg  [31:0] sr;
    reg  [5:0]  nbits;
    reg  [5:0]  need;
    reg  [4:0]  opcode;
    reg  [31:0] timer;
    reg  [3:0]  ph;
    reg         tc_ok;
    reg         prog;
    reg         chal;
    reg  [4:0]  widx;
    reg  [15:0] wdata;
    reg  [31:0] resp;
    reg  [4:0]  pcount;
    reg  [4:0]  pidx;
    reg  [1:0]  tx_state;
    reg  [17:0] tx_sr;
    reg  [4:0]  tx_left;
    reg  [2:0]  tx_ph;
    reg  [31:0] tx_timer;
    integer     k;

    wire        half_tick;
    wire        f_valid;
    wire        f_ready;
    wire        q_valid;
    wire [16:0] q_data;

    initial begin
        for (k = 0; k < `MAP_WORDS; k = k + 1) begin
            mem[k] = `CFG_DEFAULT;
        end
    end

    // serial, user and configuration slot from an opcode
    function [4:0] slot;
        input [4:0] op;
        begin
            if (op[2]) begin
                slot = `USR_BASE + {3'h0, op[1:0]};
            end else begin
                slot = op[1] ? {4'h0, op[0]} + 5'h01 : 5'h00;
            end
        end
    endfunction

    // challenge transform; hop selects the second algorithm
    function [31:0] crypt;
        input [31:0] c;
        input [63:0] key;
        input        hop;
        begin
            if (hop) begin
                crypt = ({c[15:0], c[31:16]} ^ key[63:32]) + key[31:0];
            end else begin
                crypt = (c ^ key[31:0]) + {key[47:32], key[63:48]};
            end
        end
    endfunction

    wire        dual    = cfg_active[`CFG_DUAL_BIT];
    wire [4:0]  kb      = (dual & opcode[2]) ? `KEY2_BASE : `KEY1_BASE;
    wire [63:0] key     = {mem[kb + 5'h03], mem[kb + 5'h02],
                           mem[kb + 5'h01], mem[kb]};
    wire        coil_hi = COIL_LINE_A_IN & ~COIL_LINE_A_OE;
    wire        rise    = coil_hi & ~coil_prev;
    wire        listen  = (state == ST_OPC) | (state == ST_DATA);
    wire        bit_val = (iv < `ZERO_MIN_H);
    wire        rx_bit  = rise & listen & ~ref_needed
                          & (iv >= `ONE_MIN_H);
    wire [31:0] word    = {sr[30:0], bit_val};
    wire [4:0]  op_in   = {sr[3:0], bit_val};
    wire [5:0]  nbits_n = nbits + 6'h01;
    wire        tx_idle = (tx_state == TX_IDLE);
    wire [16:0] f_data  = chal ? {pcount[1], pcount[1] ? resp[31:16]
                                                       : resp[15:0]}
                               : {1'b1, mem[pidx]};
    wire [2:0]  tx_last = tx_sr[17] ? `RSP_ONE_H : `RSP_ZERO_H;
    wire        next_drive = ((state == ST_ACK) & (ph < 4'h2))
                           | ((state == ST_WACK) & ~ph[1] & (ph < 4'h6))
                           | ((tx_state == TX_BIT) & (tx_ph < 3'h2));

    assign f_valid = (state == ST_PUSH) & (pcount != 5'h00);

    te_divider #(
        .HALF_SLOW (HALF_SLOW),
        .HALF_FAST (HALF_FAST)
    ) u_div (
        .clock (CLOCK),
        .rstn  (RSTN),
        .fast  (cfg_active[`CFG_RATE_BIT]),
        .tick  (half_tick)
    );

    word_fifo #(
        .W  (17),
        .D  (4),
        .AW (2)
    ) u_fifo (
        .clock     (CLOCK),
        .rstn      (RSTN),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (f_data),
        .out_valid (q_valid),
        .out_ready (tx_idle),
        .out_data  (q_data)
    );

    // edge interval and high-time measurement
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            coil_prev <= 1'b0;
            iv        <= 6'h00;
            hcnt      <= 4'h0;
        end else begin
            coil_prev <= coil_hi;
            if (rise) begin
                iv <= 6'h00;
            end else if (half_tick && iv != 6'h3F) begin
                iv <= iv + 6'h01;
            end
            if (!coil_hi) begin
                hcnt <= 4'h0;
            end else if (half_tick && hcnt != 4'hF) begin
                hcnt <= hcnt + 4'h1;
            end
        end
    end

    always @(posedge CLOCK) begin
        if (!RSTN) begin
            state      <= ST_OFF;
            cfg_active <= `CFG_DEFAULT;
            cfg_loaded <= 1'b0;
            ref_needed <= 1'b1;
            sr         <= 32'h0000_0000;
            nbits      <= 6'h00;
            need       <= 6'h00;
            opcode     <= 5'h00;
            timer      <= 32'h0000_0000;
            ph         <= 4'h0;
            tc_ok      <= 1'b0;
            prog       <= 1'b0;
            chal       <= 1'b0;
            widx       <= 5'h00;
            wdata      <= 16'h0000;
            resp       <= 32'h0000_0000;
            pcount     <= 5'h00;
            pidx       <= 5'h00;
        end else begin
            if (!cfg_loaded) begin
                cfg_loaded <= 1'b1;
                cfg_active <= mem[0];
            end
            if (rx_bit) begin
                sr    <= word;
                nbits <= nbits_n;
            end
            if (rise & listen & ref_needed) begin
                ref_needed <= 1'b0;
            end
            case (state)
            ST_OFF: begin
                ph    <= 4'h0;
                timer <= 32'h0000_0000;
                if (FIELD_PRESENT) begin
                    state <= ST_ACK;
                end
            end
            ST_ACK: begin
                if (half_tick) begin
                    ph <= (ph == `ACK_LAST_H) ? 4'h0 : ph + 4'h1;
                end
                if (timer != ACK_WAIT) begin
                    timer <= timer + 32'h0000_0001;
                end
                if (hcnt >= `START_MIN_H) begin
                    state      <= ST_OPC;
                    ref_needed <= 1'b0;
                    nbits      <= 6'h00;
                end else if (timer == ACK_WAIT - 32'h0000_0001
                             && cfg_active[`CFG_ECHO_BIT]) begin
                    state <= ST_RF;
                    timer <= 32'h0000_0000;
                end
            end
            ST_RF: begin
                timer <= timer + 32'h0000_0001;
                if (timer == RF_TIME - 32'h0000_0001) begin
                    state      <= ST_OPC;
                    ref_needed <= 1'b1;
                    nbits      <= 6'h00;
                end
            end
            ST_OPC: begin
                if (rx_bit && nbits_n == 6'h05) begin
                    opcode     <= op_in;
                    nbits      <= 6'h00;
                    ref_needed <= 1'b1;
                    chal       <= op_in[4];
                    prog       <= (op_in == `OP_PROGRAM);
                    widx       <= slot(op_in);
                    tc_ok      <= (op_in[4:2] == 3'b011);
                    need       <= (op_in[4:2] == 3'b011) ? 6'h10 : 6'h20;
                    if (op_in[4]) begin
                        state <= ST_DATA;
                    end else if (op_in[3]) begin
                        state <= ST_DATA;
                    end else if (op_in != `OP_SELECT) begin
                        state  <= ST_PUSH;
                        pidx   <= slot(op_in);
                        pcount <= 5'h01;
                    end
                end
            end
            ST_DATA: begin
                if (rx_bit && nbits_n == need) begin
                    nbits      <= 6'h00;
                    ref_needed <= 1'b1;
                    if (chal) begin
                        resp   <= crypt(word, key, opcode[0]);
                        pcount <= 5'h02;
                        state  <= ST_PUSH;
                    end else if (!tc_ok) begin
                        if (word == TRANSPORT) begin
                            tc_ok <= 1'b1;
                            need  <= 6'h10;
                            if (prog) begin
                                for (k = 0; k < `MAP_WORDS; k = k + 1) begin
                                    mem[k] <= 16'h0000;
                                end
                                cfg_active <= 16'h0000;
                                widx       <= 5'h00;
                            end
                        end else begin
                            state <= ST_OPC;
                        end
                    end else begin
                        wdata <= word[15:0];
                        timer <= 32'h0000_0000;
                        state <= ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                timer <= timer + 32'h0000_0001;
                if (timer == WRITE_TIME - 32'h0000_0001) begin
                    mem[widx] <= wdata;
                    ph        <= 4'h0;
                    state     <= ST_WACK;
                end
            end
            ST_WACK: begin
                if (half_tick) begin
                    ph <= ph + 4'h1;
                end
                if (ph == 4'h6) begin
                    if (prog && widx != `MAP_LAST) begin
                        widx  <= widx + 5'h01;
                        state <= ST_DATA;
                    end else if (prog) begin
                        prog   <= 1'b0;
                        pidx   <= 5'h00;
                        pcount <= `MAP_LAST + 5'h01;
                        state  <= ST_PUSH;
                    end else begin
                        state <= ST_OPC;
                    end
                end
            end
            ST_PUSH: begin
                if (f_valid && f_ready) begin
                    pcount <= pcount - 5'h01;
                    pidx   <= pidx + 5'h01;
                end
                if (pcount == 5'h00 && !q_valid && tx_idle) begin
                    state      <= ST_OPC;
                    chal       <= 1'b0;
                    ref_needed <= 1'b1;
                    nbits      <= 6'h00;
                end
            end
            default: begin
                state <= ST_OFF;
            end
            endcase
            if (!FIELD_PRESENT) begin
                state <= ST_OFF;
            end
        end
    end

    // response transmitter
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            tx_state <= TX_IDLE;
            tx_sr    <= 18'h00000;
            tx_left  <= 5'h00;
            tx_ph    <= 3'h0;
            tx_timer <= 32'h0000_0000;
        end else begin
            case (tx_state)
            TX_IDLE: begin
                tx_ph    <= 3'h0;
                tx_timer <= 32'h0000_0000;
                if (q_valid) begin
                    if (q_data[16]) begin
                        tx_sr    <= {2'b01, q_data[15:0]};
                        tx_left  <= 5'h12;
                        tx_state <= TX_WAIT;
                    end else begin
                        tx_sr    <= {q_data[15:0], 2'b00};
                        tx_left  <= 5'h10;
                        tx_state <= TX_BIT;
                    end
                end
            end
            TX_WAIT: begin
                tx_timer <= tx_timer + 32'h0000_0001;
                if (tx_timer == RESP_WAIT - 32'h0000_0001) begin
                    tx_state <= TX_BIT;
                end
            end
            TX_BIT: begin
                if (half_tick) begin
                    if (tx_ph == tx_last) begin
                        tx_ph   <= 3'h0;
                        tx_sr   <= {tx_sr[16:0], 1'b0};
                        tx_left <= tx_left - 5'h01;
                        if (tx_left == 5'h01) begin
                            tx_state <= TX_IDLE;
                        end
                    end else begin
                        tx_ph <= tx_ph + 3'h1;
                    end
                end
            end
            default: begin
                tx_state <= TX_IDLE;
            end
            endcase
        end
    end

    always @(posedge CLOCK) begin
        if (!RSTN) begin
            COIL_LINE_A_OUT      <= 1'b0;
            COIL_LINE_A_OE       <= 1'b0;
            COIL_LINE_B_OUT      <= 1'b0;
            COIL_LINE_B_OE       <= 1'b0;
            RF_ACTIVE            <= 1'b0;
            SWITCH_FUNCTION_CODE <= `SWITCH_ECHO;
            LINK_ACTIVE          <= 1'b0;
        end else begin
            COIL_LINE_A_OUT      <= next_drive;
            COIL_LINE_A_OE       <= next_drive;
            COIL_LINE_B_OUT      <= next_drive;
            COIL_LINE_B_OE       <= next_drive;
            RF_ACTIVE            <= (state == ST_RF);
            SWITCH_FUNCTION_CODE <= `SWITCH_ECHO;
            LINK_ACTIVE          <= (state != ST_OFF) && (state != ST_RF);
        end
    end
endmodule // transponder_challenge_link
`default_nettype wire

//--- verif/link_checker_asserts.sv
// Purpose: port checks of the coil link device
// Assumes: counts as set at the instance
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module link_checker #(
    parameter [15:0] HALF_SLOW = 16'h0004,
    parameter [31:0] ACK_WAIT  = 32'h0000_00C8,
    parameter [31:0] RF_TIME   = 32'h0000_0064
) (
    input wire logic       CLOCK,
    input wire logic       RSTN,
    input wire logic       FIELD_PRESENT,
    input wire logic       COIL_LINE_A_OUT,
    input wire logic       COIL_LINE_A_OE,
    input wire logic       COIL_LINE_B_OUT,
    input wire logic       COIL_LINE_B_OE,
    input wire logic       RF_ACTIVE,
    input wire logic [2:0] SWITCH_FUNCTION_CODE,
    input wire logic       LINK_ACTIVE
);
    logic [31:0] hi_cnt;
    logic [31:0] rf_cnt;
    logic [31:0] lk_cnt;
    always_ff @(posedge CLOCK) begin
        hi_cnt <= COIL_LINE_A_OE ? hi_cnt + 32'h1 : 32'h0;
        rf_cnt <= RF_ACTIVE ? rf_cnt + 32'h1 : 32'h0;
        lk_cnt <= LINK_ACTIVE ? lk_cnt + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    mirror_lines_a: assert property (
        COIL_LINE_B_OE == COIL_LINE_A_OE && COIL_LINE_B_OUT == COIL_LINE_A_OUT)
        else $error("line b differs from line a");
    drive_level_a: assert property (COIL_LINE_A_OUT == COIL_LINE_A_OE)
        else $error("drive value differs from enable");
    field_on_a: assert property ($rose(FIELD_PRESENT) && !LINK_ACTIVE
        && !RF_ACTIVE |-> ##[1:2] LINK_ACTIVE ##[0:8] COIL_LINE_A_OE)
        else $error("no acknowledge train on field entry");
    field_off_a: assert property (!FIELD_PRESENT |=> ##1
        !LINK_ACTIVE && !RF_ACTIVE && !COIL_LINE_A_OE)
        else $error("activity without field");
    rf_code_a: assert property (RF_ACTIVE |-> SWITCH_FUNCTION_CODE == 3'h0)
        else $error("wrong function code in rf send");
    rf_quiet_a: assert property (RF_ACTIVE |-> !LINK_ACTIVE && !COIL_LINE_A_OE)
        else $error("coil pulses during rf send");
    rf_wait_a: assert property ($rose(RF_ACTIVE) |-> lk_cnt >= ACK_WAIT - 32'h1)
        else $error("rf send before reply wait ended");
    rf_length_a: assert property ($fell(RF_ACTIVE) && FIELD_PRESENT |->
        rf_cnt >= RF_TIME && rf_cnt <= RF_TIME + 32'h1)
        else $error("rf send of wrong length");
    pulse_width_a: assert property (hi_cnt <= 32'(HALF_SLOW) * 2)
        else $error("coil pulse longer than one time element");
    pulse_gap_a: assert property ($fell(COIL_LINE_A_OE) && FIELD_PRESENT
        |=> !COIL_LINE_A_OE [*3])
        else $error("coil pulses too close");
    cover property ($rose(RF_ACTIVE));
    cover property ($rose(COIL_LINE_A_OE) && LINK_ACTIVE);
    cover property ($fell(FIELD_PRESENT) && LINK_ACTIVE);
endmodule // link_checker
bind transponder_challenge_link link_checker #(
    .HALF_SLOW(HALF_SLOW), .ACK_WAIT(ACK_WAIT), .RF_TIME(RF_TIME)
) chk (
    .CLOCK(CLOCK), .RSTN(RSTN), .FIELD_PRESENT(FIELD_PRESENT),
    .COIL_LINE_A_OUT(COIL_LINE_A_OUT), .COIL_LINE_A_OE(COIL_LINE_A_OE),
    .COIL_LINE_B_OUT(COIL_LINE_B_OUT), .COIL_LINE_B_OE(COIL_LINE_B_OE),
    .RF_ACTIVE(RF_ACTIVE), .SWITCH_FUNCTION_CODE(SWITCH_FUNCTION_CODE),
    .LINK_ACTIVE(LINK_ACTIVE)
);
`default_nettype wire

//--- verif/coil_decoder.sv
// Purpose: base station model on the coil line
// Assumes: line has a pull-down, te in cycles
// Notes: drives at the falling edge
`timescale 1ns/1ps
`default_nettype none
module coil_decoder #(
    parameter int TE = 8
) (
    input  wire logic clock,
    input  wire logic line,
    output var logic  drive
);
    initial drive = 1'b0;
    task automatic pulse(input int gap);
        drive <= 1'b1;
        repeat (2 * TE) @(negedge clock);
        drive <= 1'b0;
        repeat (gap) @(negedge clock);
    endtask
    // first pulse is start or reference, last one closes
    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pulse(v[i] ? 2 * TE : 4 * TE);
        end
        pulse(2 * TE);
    endtask
    task automatic recv(output logic [31:0] v, output int cnt);
        int t;
        logic prev;
        v = 32'h0;
        cnt = 0;
        t = 0;
        prev = line;
        while (t < (cnt == 0 ? 400 : 8 * TE)) begin
            @(negedge clock);
            t++;
            if (line && !prev) begin
                if (cnt > 0) v = {v[30:0], t < 5 * TE / 2};
                cnt++;
                t = 0;
            end
            prev = line;
        end
    endtask
endmodule // coil_decoder
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench of the coil link device
// Assumes: shortened counts, memory starts clear
// Notes: line is the wired or of both parties
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    errors++; $display("unexpected %s exp %0h got %0h", name, exp, got); end end
module testbench;
    localparam int H = 4;
    localparam logic [31:0] TC = 32'h1E2D_3C4B;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic field = 1'b0;
    logic a_out, a_oe, b_out, b_oe, rf, link, drive;
    logic [2:0] code;
    logic [31:0] v;
    int n, w, errors, n_compared;
    wire line_in = a_oe | b_oe | drive;
    always #2.5 clock = ~clock;
    transponder_challenge_link #(.HALF_SLOW(16'(H)), .HALF_FAST(16'(H / 2)),
        .ACK_WAIT(32'hC8), .RF_TIME(32'h64), .RESP_WAIT(32'h28),
        .WRITE_TIME(32'h28), .TRANSPORT(TC)) dut (
        .CLOCK(clock), .RSTN(rstn), .FIELD_PRESENT(field),
        .COIL_LINE_A_IN(line_in), .COIL_LINE_A_OUT(a_out),
        .COIL_LINE_A_OE(a_oe), .COIL_LINE_B_OUT(b_out), .COIL_LINE_B_OE(b_oe),
        .RF_ACTIVE(rf), .SWITCH_FUNCTION_CODE(code), .LINK_ACTIVE(link));
    coil_decoder #(.TE(2 * H)) dec (.clock(clock), .line(line_in),
        .drive(drive));
    task automatic results;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // width of the second acknowledge pulse seen
    task automatic ack_width(output int w);
        int t;
        repeat (2) begin
            w = 0;
            t = 0;
            while (!a_oe && t < 200) begin
                @(negedge clock);
                t++;
            end
            while (a_oe && w < 100) begin
                @(negedge clock);
                w++;
            end
        end
    endtask
    task automatic wait_rf(input int lim, output int seen);
        seen = 0;
        repeat (lim) begin
            @(negedge clock);
            if (rf === 1'b1) seen = 1;
        end
    endtask
    initial begin
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("idle link", 1'b0, link)
        field = 1'b1;
        ack_width(w);
        `CHK("ack width", 2 * H, w)
        dec.send(32'h0C, 5);
        dec.send(32'hA5C3, 16);
        dec.recv(v, n);
        `CHK("write ack count", 2, n)
        `CHK("write ack gap", 32'h1, v)
        $display("done: user write");
        dec.send(32'h04, 5);
        dec.recv(v, n);
        `CHK("read count", 18, n)
        `CHK("read word", 32'h8000 | (32'hA5C3 >> 1), v)
        dec.send(32'h01, 5);
        dec.recv(v, n);
        `CHK("config word", 32'h8000, v)
        dec.send(32'h10, 5);
        dec.send(32'h1234_5678, 32);
        dec.recv(v, n);
        `CHK("challenge count", 34, n)
        $display("done: reads and challenge");
        dec.send(32'h09, 5);
        dec.send(~TC, 32);
        dec.recv(v, n);
        `CHK("refused write", 0, n)
        dec.send(32'h09, 5);
        dec.send(TC, 32);
        dec.send(32'h0003, 16);
        dec.recv(v, n);
        `CHK("config ack count", 2, n)
        dec.send(32'h01, 5);
        dec.recv(v, n);
        `CHK("config stored", 32'h8001, v)
        field = 1'b0;
        repeat (4) @(negedge clock);
        field = 1'b1;
        wait_rf(300, w);
        `CHK("rf before reset", 0, w)
        $display("done: config write");
        field = 1'b0;
        rstn = 1'b0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        field = 1'b1;
        ack_width(w);
        `CHK("fast ack width", H, w)
        wait_rf(300, w);
        `CHK("rf send", 1, w)
        $display("done: rf fallback");
        results;
    end
endmodule // testbench
`default_nettype wire
